// ===== qdsw_pkg.sv
// qdsw_pkg: constants shared by both ends of the dac serial write link
// assumes a 200 MHz system clock on each end
package qdsw_pkg;
	localparam int unsigned QDSW_WORD_BITS = 16;
	localparam int unsigned QDSW_CNT_W = 5;
	localparam int unsigned QDSW_SYS_MHZ = 200;
	// power-down exit delay in nanoseconds
	localparam int unsigned QDSW_PD_EXIT_NS = 2500;
	localparam int unsigned QDSW_PD_EXIT_CYC =
		(QDSW_PD_EXIT_NS * QDSW_SYS_MHZ + 999) / 1000;
	localparam int unsigned QDSW_PD_CNT_W = 10;
	// host link clock half period in system cycles
	localparam int unsigned QDSW_HALF_DIV = 8;
	localparam int unsigned QDSW_DIV_W = 8;
	localparam logic [QDSW_WORD_BITS-1:0] QDSW_WORD_RST = 16'h0000;
	typedef enum logic [1:0] {
		QDSW_IDLE = 2'b00,
		QDSW_LOW = 2'b01,
		QDSW_HIGH = 2'b11,
		QDSW_END = 2'b10
	} qdsw_state_type;
endpackage : qdsw_pkg

// ===== qdsw_if.sv
// qdsw_if: three-wire link plus chain output between host and device
// assumes the bench samples these nets, and drives the host side itself when no host is attached
`timescale 1ns/100ps
interface qdsw_if;
	logic sclk;
	logic sync_n;
	logic din;
	logic serial_data_out;
	modport host (output sclk, output sync_n, output din,
		input serial_data_out);
	modport dev (input sclk, input sync_n, input din,
		output serial_data_out);
endinterface : qdsw_if

// ===== qdsw_dev.sv
// qdsw_dev: device end, shifts in 16-bit words on falling link clock
// assumes link pins are asynchronous to i_sys_clk
//
// Summary of operation
// R1 - output release follows power-down rise after delay
// R2 - data bit sampled on falling link clock
// R3 - host makes clock, low frame, 16-bit words
// R4 - host changes data on rising clock edges
// R5 - spi host uses cpol 0, cpha 1
// R6 - byte host holds frame across two bytes
// R7 - most significant bit comes first
// R8 - falling-shift host drives clock inverted
// R9 - only one frame select active at once
// R10 - decoder disabled while addresses change
// R11 - chain enable high passes data onward
// R12 - 16 edges taken, then standalone ignores clocks
// R13 - early frame rise abandons the word
// R14 - overflow bits driven out on rising edge
// R15 - host gives exactly 16N clocks per frame
`timescale 1ns/100ps
module qdsw_dev
	import qdsw_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// link
	qdsw_if.dev link,
	// user side
	input wire logic i_chain_enable,
	input wire logic i_power_down_n,
	output logic [qdsw_pkg::QDSW_WORD_BITS-1:0] o_word,
	output logic o_word_valid,
	output logic o_out_enable
);
	import qdsw_pkg::*;
	// two-flop synchroniser for all pins: link, chain enable, power-down
	logic [4:0] s1_q, s2_q, s1_d, s2_d;
	logic sck_prev_q, sck_prev_d;
	logic [QDSW_WORD_BITS-1:0] sh_q, sh_d, word_q, word_d;
	logic [QDSW_CNT_W-1:0] cnt_q, cnt_d;
	logic vld_q, vld_d, sdo_q, sdo_d, oe_q, oe_d;
	logic [QDSW_PD_CNT_W-1:0] pd_q, pd_d;
	logic sck, syn_n, dat, chain, pdn, fall, rise;
	assign sck = s2_q[0];
	assign syn_n = s2_q[1];
	assign dat = s2_q[2];
	assign chain = s2_q[3];
	assign pdn = s2_q[4];
	assign fall = sck_prev_q & ~sck;
	assign rise = ~sck_prev_q & sck;
	always_comb begin
		s1_d = {i_power_down_n, i_chain_enable, link.din, link.sync_n,
			link.sclk};
		s2_d = s1_q;
		sck_prev_d = sck;
		sh_d = sh_q;
		cnt_d = cnt_q;
		word_d = word_q;
		vld_d = 1'b0;
		sdo_d = sdo_q;
		if (syn_n) begin
			cnt_d = '0; // R13
		end else if (fall && (chain || cnt_q < 5'(QDSW_WORD_BITS))) begin
			sh_d = {sh_q[QDSW_WORD_BITS-2:0], dat}; // R2 R7 R11 R12
			if (cnt_q < 5'(QDSW_WORD_BITS))
				cnt_d = cnt_q + 5'h01;
			if (cnt_q == 5'(QDSW_WORD_BITS - 1) && !chain) begin
				word_d = {sh_q[QDSW_WORD_BITS-2:0], dat};
				vld_d = 1'b1;
			end
		end
		if (chain && !syn_n && rise)
			sdo_d = sh_q[QDSW_WORD_BITS-1]; // R14
		if (chain && !sck_prev_q && syn_n == 1'b1 && cnt_q == 5'(QDSW_WORD_BITS)) begin
			word_d = sh_q;
			vld_d = 1'b1;
		end
		pd_d = pd_q;
		oe_d = oe_q;
		if (!pdn) begin
			pd_d = '0;
			oe_d = 1'b0;
		end else if (pd_q < 10'(QDSW_PD_EXIT_CYC)) begin
			pd_d = pd_q + 10'h001;
		end else begin
			oe_d = 1'b1; // R1
		end
	end
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			// idle levels: clock low, frame high, so no false edge
			s1_q <= 5'h02;
			s2_q <= 5'h02;
			sck_prev_q <= 1'b0;
			sh_q <= QDSW_WORD_RST;
			cnt_q <= '0;
			word_q <= QDSW_WORD_RST;
			vld_q <= 1'b0;
			sdo_q <= 1'b0;
			pd_q <= '0;
			oe_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			sck_prev_q <= sck_prev_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			word_q <= word_d;
			vld_q <= vld_d;
			sdo_q <= sdo_d;
			pd_q <= pd_d;
			oe_q <= oe_d;
		end
	end
	assign link.serial_data_out = sdo_q;
	assign o_word = word_q;
	assign o_word_valid = vld_q;
	assign o_out_enable = oe_q;
endmodule : qdsw_dev

// ===== qdsw_host.sv
// qdsw_host: host end, sends one 16-bit word per frame, msb first
// assumes i_start is a one-cycle pulse from same-clock logic
`timescale 1ns/100ps
module qdsw_host
	import qdsw_pkg::*;
#(
	parameter int unsigned CHAIN_LEN = 1
)(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// link
	qdsw_if.host link,
	// user side
	input wire logic i_start,
	input wire logic [qdsw_pkg::QDSW_WORD_BITS-1:0] i_word,
	output logic o_busy,
	output logic o_done
);
	import qdsw_pkg::*;
	// bit counter is 8 bits wide, chain of at most 8 words
	if (CHAIN_LEN < 1 || CHAIN_LEN > 8) begin : g_len_check
		$error("chain length out of range");
	end
	localparam int unsigned NBITS = QDSW_WORD_BITS * CHAIN_LEN;
	qdsw_state_type st_q, st_d;
	logic [QDSW_DIV_W-1:0] div_q, div_d;
	logic [7:0] bit_q, bit_d;
	logic [QDSW_WORD_BITS-1:0] sh_q, sh_d;
	logic sck_q, sck_d, syn_q, syn_d, din_q, din_d, done_q, done_d;
	logic tick;
	assign tick = (div_q == 8'(QDSW_HALF_DIV - 1));
	always_comb begin
		st_d = st_q;
		div_d = tick ? '0 : div_q + 8'h01;
		bit_d = bit_q;
		sh_d = sh_q;
		sck_d = sck_q;
		syn_d = syn_q;
		din_d = din_q;
		done_d = 1'b0;
		case (st_q)
			QDSW_IDLE: begin
				div_d = '0;
				if (i_start) begin
					sh_d = i_word;
					bit_d = '0;
					syn_d = 1'b0; // R3 R9
					st_d = QDSW_LOW;
				end
			end
			QDSW_LOW: if (tick) begin
				sck_d = 1'b1;
				din_d = sh_q[QDSW_WORD_BITS-1]; // R4 R5 R7
				sh_d = {sh_q[QDSW_WORD_BITS-2:0], 1'b0};
				st_d = QDSW_HIGH;
			end
			QDSW_HIGH: if (tick) begin
				sck_d = 1'b0;
				bit_d = bit_q + 8'h01;
				if (bit_q == 8'(NBITS - 1))
					st_d = QDSW_END; // R6 R15
				else
					st_d = QDSW_LOW;
			end
			QDSW_END: if (tick) begin
				syn_d = 1'b1;
				done_d = 1'b1;
				st_d = QDSW_IDLE;
			end
			default: st_d = QDSW_IDLE;
		endcase
	end
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= QDSW_IDLE;
			div_q <= '0;
			bit_q <= '0;
			sh_q <= QDSW_WORD_RST;
			sck_q <= 1'b0;
			syn_q <= 1'b1;
			din_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			sck_q <= sck_d;
			syn_q <= syn_d;
			din_q <= din_d;
			done_q <= done_d;
		end
	end
	assign link.sclk = sck_q;
	assign link.sync_n = syn_q;
	assign link.din = din_q;
	assign o_busy = syn_q == 1'b0;
	assign o_done = done_q;
endmodule : qdsw_host

// ===== qdsw_chk.sv
// qdsw_chk: link timing checks
// assumes the bench feeds it link nets
`timescale 1ns/100ps
module qdsw_chk #(parameter int unsigned CHAIN_LEN = 1)(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic din,
	input wire logic serial_data_out
);
	logic [7:0] f_q, f_d;
	logic c_q;
	always_comb f_d = sync_n ? 8'h00 : f_q + {7'h00, c_q & ~sclk};
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst) {f_q, c_q} <= 9'h000;
		else {f_q, c_q} <= {f_d, sclk};
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	sequence hi_half; sclk [*8] ##1 !sclk; endsequence
	a_idle_low: assert property (sync_n |-> !sclk)
		else $error("idle clk");
	a_half_period: assert property ($rose(sclk) |-> hi_half)
		else $error("half");
	a_frame_open: assert property ($fell(sync_n) |-> !sclk [*4])
		else $error("open");
	a_din_on_rise: assert property (
		!sync_n && !$fell(sync_n) && $changed(din) |-> $rose(sclk))
		else $error("din edge");
	a_din_steady: assert property ($fell(sclk) |-> $stable(din))
		else $error("din");
	a_sdo_rise: assert property ($changed(serial_data_out) |-> sclk)
		else $error("sdo");
	a_frame_count: assert property (
		$rose(sync_n) |-> f_q == 16 * CHAIN_LEN)
		else $error("count");
	a_frame_held: assert property (
		$fell(sclk) && f_q < 16 * CHAIN_LEN - 1 |=> !sync_n)
		else $error("short");
endmodule : qdsw_chk

// ===== tb_quad_dac_serial_write_port.sv
// tb: host to device link plus a bench-driven device
// assumes design files and checker come first
`timescale 1ns/100ps
module tb_quad_dac_serial_write_port;
	import qdsw_pkg::*;
	logic i_sys_clk = 0, i_rst = 1, i_start = 0, ce = 0, pd = 1;
	logic o_done, o_word_valid, v2, oe;
	logic [15:0] i_word, o_word, wd2, q[$];
	logic [31:0] r = 32'hA5EE9666, d;
	int error_cnt = 0, total_checks = 0, n2 = 0, t;
	qdsw_if l();
	qdsw_if m();
	qdsw_host #(.CHAIN_LEN(1)) qdsw_host_i(.*, .link(l), .o_busy());
	qdsw_dev qdsw_dev_i(.*, .link(l), .i_chain_enable(ce),
		.i_power_down_n(pd), .o_out_enable(oe));
	qdsw_dev qdsw_dev_i2(.i_sys_clk, .i_rst, .link(m),
		.i_chain_enable(ce), .i_power_down_n(pd), .o_word(wd2),
		.o_word_valid(v2), .o_out_enable());
	qdsw_chk #(.CHAIN_LEN(1)) qdsw_chk_i(.i_sys_clk, .i_rst,
		.sclk(l.sclk), .sync_n(l.sync_n), .din(l.din),
		.serial_data_out(l.serial_data_out));
	always #2.5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		n2 <= n2 + v2;
		if (o_word_valid === 1'b1) cmp("word", q.pop_front(), o_word);
	end
	task tk(int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : tk
	task cmp(string s, logic [15:0] e, g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h saw %h", s, e, g);
		end
	endtask : cmp
	function automatic logic [31:0] rnd();
		r ^= r << 13;
		r ^= r >> 17;
		r ^= r << 5;
		return r;
	endfunction : rnd
	task bb(int n, logic [31:0] b);
		m.sync_n = 0;
		tk(8);
		for (int i = 0; i < n; i++) begin
			m.sclk = 1;
			m.din = b[31-i];
			tk(8);
			if (ce && i > 15)
				cmp("sdo", 16'(b[47-i]), 16'(m.serial_data_out));
			m.sclk = 0;
			tk(8);
		end
		m.sync_n = 1;
		m.din = ~m.din;
		tk(16);
	endtask : bb
	task results();
		$display("%0d checks %0d errors", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	initial begin
		{m.sclk, m.sync_n, m.din} = 3'b010;
		tk(6);
		i_rst = 0;
		for (int k = 0; k < 8; k++) begin
			i_word = 16'(rnd());
			ce = i_word[0];
			q.push_back(i_word);
			i_start = 1;
			tk(1);
			i_start = 0;
			for (t = 0; t < 999 && o_done !== 1'b1; t++) tk(1);
			if (t > 998) begin
				error_cnt++;
				results();
			end
			tk(8);
		end
		ce = 0;
		bb(10, rnd());
		cmp("abort", 16'(n2), 16'h0000);
		d = rnd();
		bb(20, d);
		cmp("alone", d[31:16], wd2);
		ce = 1;
		bb(20, d);
		cmp("chain", d[27:12], wd2);
		cmp("count", 16'(n2), 16'h0002);
		pd = 0;
		tk(9);
		cmp("off", 16'(oe), 16'h0000);
		pd = 1;
		for (t = 0; t < 999 && oe !== 1'b1; t++) tk(1);
		cmp("on", 16'(t / 8), 16'(QDSW_PD_EXIT_CYC / 8));
		results();
	end
endmodule : tb_quad_dac_serial_write_port
